// *** hdl/aoc_pkg.sv ***
// shared constants and types for the analog output controller and its channel controllers
package aoc_pkg;

  // apb register map of the controller, byte addresses
  localparam int           APB_ADDR_W   = 8;
  localparam logic [7:0]   REG_INSTR    = 8'h00;   // write: instruction code and device address
  localparam logic [7:0]   REG_COUNT    = 8'h04;   // read/write: conversions per start
  localparam logic [7:0]   REG_RESULT   = 8'h08;   // read: status of the last instruction
  localparam logic [7:0]   REG_STATE    = 8'h0C;   // read: live state and remaining count

  // instruction register fields
  localparam int           INSTR_CODE_LSB = 0;
  localparam int           INSTR_ADDR_LSB = 8;
  localparam logic [2:0]   I_START      = 3'h1;
  localparam logic [2:0]   I_TEST       = 3'h2;
  localparam logic [2:0]   I_HALT       = 3'h3;
  localparam logic [2:0]   I_TDV        = 3'h4;
  localparam logic [2:0]   I_ACK        = 3'h5;

  // result register bit positions
  localparam int           RES_ADDR_OK  = 0;
  localparam int           RES_BUSY     = 1;
  localparam int           RES_INT_PEND = 2;
  localparam int           RES_UNUSUAL  = 3;
  localparam int           RES_SIO_OK   = 4;
  localparam int           RES_SIO_DONE = 5;
  localparam int           RES_HIO_BUSY = 6;
  localparam int           RES_RATE_ERR = 7;
  localparam int           RES_FCU      = 8;
  localparam int           RES_CAUSE    = 10;   // two bits

  // interrupt causes
  localparam logic [1:0]   CAUSE_NONE    = 2'h0;
  localparam logic [1:0]   CAUSE_CHEND   = 2'h1;
  localparam logic [1:0]   CAUSE_UNUSUAL = 2'h2;

  // channel order and record control codes
  localparam logic [7:0]   ORDER_WRITE  = 8'h01;
  localparam logic [1:0]   CODE_LOAD    = 2'h0;
  localparam logic [1:0]   CODE_XFER    = 2'h1;
  localparam logic [1:0]   CODE_EXT     = 2'h3;

  // record layout, first byte fetched lands in the top byte
  localparam int           REC_CODE_LSB = 30;   // control bits 0-1
  localparam int           REC_SEL_LSB  = 16;   // converter address byte
  localparam int           SEL_CTRL_LSB = 4;    // channel controller nibble of the select byte
  localparam int           BYTES_PER_REC = 4;

  // bus geometry
  localparam int           NUM_CTRL     = 16;
  localparam int           CONV_PER_CTRL = 16;

  // pulse timing
  localparam int           CLK_FREQ_MHZ = 100;
  localparam int           STROBE_NS    = 1000;
  localparam int           CONVERT_NS   = 1000;
  localparam int           STROBE_CYC   = (STROBE_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int           CONVERT_CYC  = (CONVERT_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int           TIMER_W      = 8;

  // controller sequencing states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_ORDER   = 4'b0001,
    ST_FETCH   = 4'b0010,
    ST_SETUP   = 4'b0011,
    ST_STROBE  = 4'b0100,
    ST_HOLD    = 4'b0101,
    ST_CONVERT = 4'b0110,
    ST_WAITEXT = 4'b0111,
    ST_NEXT    = 4'b1000
  } aoc_state_e;

endpackage

// *** hdl/aoc_dac_bus_if.sv ***
// data/control bus from the controller to the d-to-a channel controllers
`timescale 1ns/1ps
interface aoc_dac_bus_if;
  logic [15:0] data;     // conversion word
  logic [7:0]  sel;      // channel controller and converter select
  logic        strobe;   // select lines valid
  logic        convert;  // common rank transfer

  modport ctl (output data, output sel, output strobe, output convert);
  modport chan (input data, input sel, input strobe, input convert);
endinterface

// *** hdl/aoc_controller.sv ***
// analog output controller: i/o channel side, apb instruction registers, d-to-a bus driver
//
// Functional notes
// - sixteen channel controllers, one i/o channel
// - converters double-ranked, second rank converted
// - convert reaches all converters at once
// - start requests order, expects write order 01
// - four bytes fetched per conversion
// - repeat until programmed conversion count done
// - unusual end on halt or rate error
// - channel end when last conversion starts
// - respond only to switch-set device address
// - start/test/halt return common plus specific status
// - test device returns rate error, frequency unit
// - acknowledge returns interrupt cause
// - record: control, unit number, data word
// - code 00 loads first rank only
// - code 01 loads then pulses convert
// - code 11 loads, waits external transfer
// - unit byte: controller nibble, converter nibble
// - data is left-justified two's complement
// - data lines stable throughout strobe
// - select lines stable, decoded by controllers
// - select strobe one microsecond wide
// - common convert pulse one microsecond
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module aoc_controller
  import aoc_pkg::*;
#(
  parameter int COUNT_W = 16                  // width of the conversion counter
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RESET_N,
  // apb slave
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [APB_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // i/o channel byte service
  output logic                       ORDER_REQ,
  input  wire logic                  ORDER_VALID,
  input  wire logic [7:0]            ORDER_BYTE,
  output logic                       DATA_REQ,
  input  wire logic                  DATA_VALID,
  input  wire logic [7:0]            DATA_BYTE,
  input  wire logic                  CHANNEL_HALT,
  output logic                       UNUSUAL_END,
  output logic                       CHANNEL_END,
  // pins
  input  wire logic [7:0]            DEV_SWITCH,
  input  wire logic                  EXT_TRANSFER,
  input  wire logic                  FCU_PRESENT,
  // d-to-a bus
  aoc_dac_bus_if.ctl                 bus
);

  // refuse widths the counter and timers cannot serve
  if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count
    $error("COUNT_W must be 1 to 32");
  end
  if (STROBE_CYC < 1 || STROBE_CYC >= (1 << TIMER_W) || CONVERT_CYC >= (1 << TIMER_W)) begin : g_bad_timer
    $error("pulse length does not fit the timer");
  end

  // every piece of state in one record
  typedef struct packed {
    aoc_state_e         state;
    logic [1:0]         byte_idx;     // bytes of the record taken so far
    logic [31:0]        rec;          // assembled record
    logic [COUNT_W-1:0] remain;       // conversions still to do
    logic [COUNT_W-1:0] count_cfg;    // programmed conversions per start
    logic [TIMER_W-1:0] timer;        // pulse width down-counter
    logic               order_req;
    logic               data_req;
    logic [15:0]        data;
    logic [7:0]         sel;
    logic               strobe;
    logic               convert;
    logic               unusual_end;
    logic               channel_end;
    logic               int_pend;
    logic [1:0]         int_cause;
    logic               last_unusual;
    logic               rate_err;
    logic [15:0]        result;
    logic [7:0]         sw_s1;        // synchroniser first stages
    logic [7:0]         sw_s2;
    logic               ext_s1;
    logic               ext_s2;
    logic               ext_d;        // edge detector behind the synchroniser
    logic               fcu_s1;
    logic               fcu_s2;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } aoc_ctl_s;

  aoc_ctl_s r;      // registered state
  aoc_ctl_s n;      // next state

  logic               busy;           // a start is in progress
  logic               ext_pulse;      // one cycle per external transfer edge
  logic               apb_wr;         // write completing this edge
  logic               instr_wr;       // write to the instruction register
  logic [2:0]         instr_code;
  logic               addr_ok;        // instruction names our switch address
  logic               do_halt;
  logic               abort;
  logic               rate_hit;

  // next-state logic
  always_comb begin
    n = r;
    n.unusual_end = 1'b0;
    n.channel_end = 1'b0;

    // pins pass two flip-flops before use
    n.sw_s1  = DEV_SWITCH;
    n.sw_s2  = r.sw_s1;
    n.ext_s1 = EXT_TRANSFER;
    n.ext_s2 = r.ext_s1;
    n.ext_d  = r.ext_s2;
    n.fcu_s1 = FCU_PRESENT;
    n.fcu_s2 = r.fcu_s1;
    ext_pulse = r.ext_s2 & ~r.ext_d;

    busy       = (r.state != ST_IDLE);
    apb_wr     = PSEL && PENABLE && PWRITE && r.pready;
    instr_wr   = apb_wr && (PADDR == REG_INSTR);
    instr_code = PWDATA[INSTR_CODE_LSB +: 3];
    addr_ok    = (PWDATA[INSTR_ADDR_LSB +: 8] == r.sw_s2);
    do_halt    = 1'b0;
    rate_hit   = 1'b0;

    // apb: ready one cycle after setup, read data captured with it
    n.pready  = PSEL && !PENABLE && !r.pready;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (PSEL && !PENABLE) begin
      case (PADDR)
        REG_INSTR:  n.prdata = 32'h0000_0000;
        REG_COUNT:  n.prdata = 32'(r.count_cfg);
        REG_RESULT: n.prdata = 32'(r.result);
        REG_STATE:  n.prdata = {12'h000, r.remain[COUNT_W-1:0] & {COUNT_W{1'b1}}, 4'(r.state)} & 32'hFFFF_FFFF;
        default:    n.pslverr = 1'b1;     // unmapped address
      endcase
    end
    if (apb_wr && PADDR == REG_COUNT) begin
      n.count_cfg = PWDATA[COUNT_W-1:0];
    end

    // i/o instructions
    if (instr_wr) begin
      n.result = 16'h0000;
      if (addr_ok) begin
        n.result[RES_ADDR_OK] = 1'b1;
        case (instr_code)
          I_START: begin
            n.result[RES_BUSY]     = busy;
            n.result[RES_INT_PEND] = r.int_pend;
            n.result[RES_UNUSUAL]  = r.last_unusual;
            if (!busy && r.count_cfg != '0) begin
              n.result[RES_SIO_DONE] = 1'b1;
              n.state        = ST_ORDER;
              n.order_req    = 1'b1;
              n.remain       = r.count_cfg;
              n.last_unusual = 1'b0;
              n.rate_err     = 1'b0;
            end
          end
          I_TEST: begin
            n.result[RES_BUSY]     = busy;
            n.result[RES_INT_PEND] = r.int_pend;
            n.result[RES_UNUSUAL]  = r.last_unusual;
            n.result[RES_SIO_OK]   = !busy && r.count_cfg != '0;
          end
          I_HALT: begin
            n.result[RES_BUSY]     = busy;
            n.result[RES_INT_PEND] = r.int_pend;
            n.result[RES_UNUSUAL]  = r.last_unusual;
            n.result[RES_HIO_BUSY] = busy;
            do_halt = busy;
          end
          I_TDV: begin
            n.result[RES_RATE_ERR] = r.rate_err;
            n.result[RES_FCU]      = r.fcu_s2;
          end
          I_ACK: begin
            n.result[RES_INT_PEND] = r.int_pend;
            n.result[RES_CAUSE +: 2] = r.int_cause;
            n.int_pend  = 1'b0;    // later events in this cycle set it again
            n.int_cause = CAUSE_NONE;
          end
          default: n.result = 16'h0000;
        endcase
      end
    end

    // conversion sequencer
    case (r.state)
      ST_IDLE: begin
        n.strobe = 1'b0;
      end
      ST_ORDER: begin
        if (ORDER_VALID) begin
          n.order_req = 1'b0;
          if (ORDER_BYTE == ORDER_WRITE) begin
            n.state    = ST_FETCH;
            n.data_req = 1'b1;
            n.byte_idx = 2'h0;
          end else begin
            do_halt = 1'b1;                                 // unknown order ends abnormally
          end
        end
      end
      ST_FETCH: begin
        if (DATA_VALID) begin
          n.rec      = {r.rec[23:0], DATA_BYTE};
          n.byte_idx = r.byte_idx + 2'h1;
          if (r.byte_idx == 2'(BYTES_PER_REC - 1)) begin
            n.data_req = 1'b0;
            n.data     = {r.rec[7:0], DATA_BYTE};
            n.sel      = r.rec[15:8];
            n.state    = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        // lines settled a cycle before the strobe rises
        n.strobe = 1'b1;
        n.timer  = TIMER_W'(STROBE_CYC - 1);
        n.state  = ST_STROBE;
        if (r.remain == COUNT_W'(1)) begin
          n.channel_end = 1'b1;
          n.int_pend    = 1'b1;
          n.int_cause   = CAUSE_CHEND;
        end
      end
      ST_STROBE: begin
        if (r.timer == '0) begin
          n.strobe = 1'b0;
          n.state  = ST_HOLD;
        end else begin
          n.timer = r.timer - TIMER_W'(1);
        end
      end
      ST_HOLD: begin
        case (r.rec[REC_CODE_LSB +: 2])
          CODE_XFER: begin
            n.convert = 1'b1;
            n.timer   = TIMER_W'(CONVERT_CYC - 1);
            n.state   = ST_CONVERT;
          end
          CODE_EXT:  n.state = ST_WAITEXT;
          default:   n.state = ST_NEXT;
        endcase
      end
      ST_WAITEXT: begin
        if (ext_pulse) begin
          n.convert = 1'b1;
          n.timer   = TIMER_W'(CONVERT_CYC - 1);
          n.state   = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (r.timer == '0) begin
          n.convert = 1'b0;
          n.state   = ST_NEXT;
        end else begin
          n.timer = r.timer - TIMER_W'(1);
        end
      end
      ST_NEXT: begin
        n.remain = r.remain - COUNT_W'(1);
        if (r.remain == COUNT_W'(1)) begin
          n.state = ST_IDLE;
        end else begin
          n.state    = ST_FETCH;
          n.data_req = 1'b1;
          n.byte_idx = 2'h0;
        end
      end
      default: n.state = ST_IDLE;
    endcase

    // abnormal end overrides the sequencer
    rate_hit = busy && ext_pulse && (r.state != ST_WAITEXT);
    abort    = do_halt || (busy && CHANNEL_HALT) || rate_hit;
    if (abort) begin
      n.state        = ST_IDLE;
      n.order_req    = 1'b0;
      n.data_req     = 1'b0;
      n.strobe       = 1'b0;
      n.convert      = 1'b0;
      n.unusual_end  = 1'b1;
      n.last_unusual = 1'b1;
      n.int_pend     = 1'b1;
      n.int_cause    = CAUSE_UNUSUAL;
      n.rate_err     = r.rate_err | rate_hit;
    end
  end

  // single state register, constants on reset
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      r       <= '0;
      r.state <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign PRDATA      = r.prdata;
  assign PREADY      = r.pready;
  assign PSLVERR     = r.pslverr;
  assign ORDER_REQ   = r.order_req;
  assign DATA_REQ    = r.data_req;
  assign UNUSUAL_END = r.unusual_end;
  assign CHANNEL_END = r.channel_end;
  assign bus.data    = r.data;
  assign bus.sel     = r.sel;
  assign bus.strobe  = r.strobe;
  assign bus.convert = r.convert;

endmodule

// *** hdl/aoc_chan_ctrl.sv ***
// d-to-a channel controller: decodes select lines, holds two register ranks per converter
`timescale 1ns/1ps
module aoc_chan_ctrl
  import aoc_pkg::*;
#(
  parameter logic [3:0] CTRL_ID  = 4'h0,            // this controller's select nibble
  parameter int         NUM_CONV = CONV_PER_CTRL    // converters fitted
) (
  input  wire logic                     CLOCK,
  input  wire logic                     RESET_N,
  aoc_dac_bus_if.chan                   bus,
  output logic [NUM_CONV-1:0][15:0]     ANALOG_OUT, // second ranks, the converted words
  output logic [NUM_CONV-1:0]           PENDING     // first rank loaded since last transfer
);

  // a converter index wider than the select nibble cannot be reached
  if (NUM_CONV < 1 || NUM_CONV > CONV_PER_CTRL) begin : g_bad_conv
    $error("NUM_CONV must be 1 to 16");
  end

  typedef struct packed {
    logic [NUM_CONV-1:0][15:0] rank1;     // loaded by strobe
    logic [NUM_CONV-1:0][15:0] rank2;     // loaded by convert
    logic [NUM_CONV-1:0]       pending;
    logic                      strobe_d;  // edge detectors, bus is on this clock
    logic                      convert_d;
  } aoc_chan_s;

  aoc_chan_s r;
  aoc_chan_s n;
  logic [3:0] conv_idx;                   // converter nibble of the select byte

  // load on strobe rise, transfer on convert rise
  always_comb begin
    n = r;
    n.strobe_d  = bus.strobe;
    n.convert_d = bus.convert;
    conv_idx    = bus.sel[3:0];
    if (bus.strobe && !r.strobe_d && bus.sel[SEL_CTRL_LSB +: 4] == CTRL_ID) begin
      for (int i = 0; i < NUM_CONV; i++) begin
        if (conv_idx == 4'(i)) begin
          n.rank1[i]   = bus.data;
          n.pending[i] = 1'b1;
        end
      end
    end
    if (bus.convert && !r.convert_d) begin
      // every converter copies; unchanged ones just keep their output
      n.rank2   = r.rank1;
      n.pending = '0;
    end
  end

  // single state register
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ANALOG_OUT = r.rank2;
  assign PENDING    = r.pending;

endmodule

// *** tb/aoc_bus_assertions.sv ***
// concurrent checks on the bus between the controller and its channel controllers
`timescale 1ns/1ps
module aoc_bus_assertions
  import aoc_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic [15:0] data,
  input  wire logic [7:0]  sel,
  input  wire logic        strobe,
  input  wire logic        convert
);
  // 1.0 us at a 10 ns clock
  localparam int PULSE_CYC = 100;

  // run lengths of the two pulses
  typedef struct packed {
    logic [7:0] str_len;  // cycles strobe has stood high
    logic [7:0] cnv_len;  // cycles convert has stood high
  } aoc_len_s;

  aoc_len_s len_r;        // registered run lengths
  aoc_len_s len_nxt;      // next run lengths

  // count while high, clear when low; 8 bits cover the pulse with margin
  always_comb begin
    len_nxt         = len_r;
    len_nxt.str_len = strobe ? len_r.str_len + 8'h01 : 8'h00;
    len_nxt.cnv_len = convert ? len_r.cnv_len + 8'h01 : 8'h00;
  end

  // async clear so the counts never span a reset
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      len_r <= '0;
    end else begin
      len_r <= len_nxt;
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  strobe_width_a: assert property ($fell(strobe) |-> len_r.str_len == PULSE_CYC)
    else $error("select strobe width wrong");
  strobe_max_a: assert property (len_r.str_len <= PULSE_CYC)
    else $error("select strobe too long");
  convert_width_a: assert property ($fell(convert) |-> len_r.cnv_len == PULSE_CYC)
    else $error("convert pulse width wrong");
  convert_max_a: assert property (len_r.cnv_len <= PULSE_CYC)
    else $error("convert pulse too long");
  data_stable_a: assert property (strobe |-> $stable(data))
    else $error("data lines moved during strobe");
  sel_stable_a: assert property (strobe |-> $stable(sel))
    else $error("select lines moved during strobe");
  sel_hold_a: assert property ($fell(strobe) |-> $stable(sel) && $stable(data))
    else $error("select lines not held to strobe end");
  convert_apart_a: assert property ($rose(convert) |-> !strobe && !$past(strobe))
    else $error("convert overlaps the strobe");
  strobe_gap_a: assert property ($fell(strobe) |-> !strobe [*2])
    else $error("strobe restarted at once");
endmodule

// *** tb/tb_analog_output_controller.sv ***
// self-checking bench: controller and two channel controllers joined by the bus interface
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_analog_output_controller
  import aoc_pkg::*;
;
  logic        clock, reset_n, psel, penable, pwrite, order_valid, data_valid, chan_halt, ext_xfer, fcu;
  logic [7:0]  paddr, order_byte, data_byte, dev_sw;
  logic [31:0] pwdata, prdata, rd;      // rd: data of the last apb transfer
  logic        pready, pslverr, rerr, order_req, data_req, unusual_end, channel_end, cnv_q;
  logic [15:0][15:0] ao0;               // second ranks of controller 0
  logic [4:0][15:0]  ao1;               // second ranks of controller 5, five fitted
  logic [15:0] r1 [2][16];              // model first ranks
  logic [15:0] r2 [2][16];              // model second ranks
  logic [1:0]  codes [4] = '{CODE_LOAD, CODE_XFER, CODE_EXT, 2'h2};
  logic [3:0]  nibs [3] = '{4'h0, 4'h5, 4'h9};  // 9 selects nobody
  int          n_fail, comparisons, n_chend, n_unus, n_conv, cyc, seed;

  always #5 clock = ~clock;

  aoc_dac_bus_if bus_if ();
  aoc_controller u_aoc_controller (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ORDER_REQ(order_req), .ORDER_VALID(order_valid), .ORDER_BYTE(order_byte), .DATA_REQ(data_req),
    .DATA_VALID(data_valid), .DATA_BYTE(data_byte), .CHANNEL_HALT(chan_halt), .UNUSUAL_END(unusual_end),
    .CHANNEL_END(channel_end), .DEV_SWITCH(dev_sw), .EXT_TRANSFER(ext_xfer), .FCU_PRESENT(fcu),
    .bus(bus_if.ctl));
  aoc_chan_ctrl #(.CTRL_ID(4'h0)) u_aoc_chan_ctrl_0 (.CLOCK(clock), .RESET_N(reset_n),
    .bus(bus_if.chan), .ANALOG_OUT(ao0), .PENDING());
  aoc_chan_ctrl #(.CTRL_ID(4'h5), .NUM_CONV(5)) u_aoc_chan_ctrl_1 (.CLOCK(clock), .RESET_N(reset_n),
    .bus(bus_if.chan), .ANALOG_OUT(ao1), .PENDING());
  aoc_bus_assertions u_aoc_bus_assertions (.CLOCK(clock), .RESET_N(reset_n), .data(bus_if.data),
    .sel(bus_if.sel), .strobe(bus_if.strobe), .convert(bus_if.convert));

  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // pulse counters, timeout, and channel end tied to the first strobe cycle
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
    if (channel_end === 1'b1) begin
      n_chend++;
      `CHK(bus_if.strobe, 1'b1)
    end
    if (unusual_end === 1'b1)
      n_unus++;
    if (bus_if.convert === 1'b1 && cnv_q !== 1'b1)
      n_conv++;
    cnv_q = bus_if.convert;
  end

  // one apb transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd      = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // issue an instruction, then fetch its status word
  task automatic instr(input logic [2:0] code, input logic [7:0] addr);
    apb(1'b1, REG_INSTR, {16'h0000, addr, 5'h00, code});
    apb(1'b0, REG_RESULT, 32'h0000_0000);
  endtask

  // model of both ranks for one record
  function automatic void model_rec(input logic [1:0] code, input logic [7:0] sel, input logic [15:0] d);
    int k;
    k = (sel[7:4] == 4'h0) ? 0 : (sel[7:4] == 4'h5 && sel[3:0] < 5) ? 1 : -1;
    if (k >= 0)
      r1[k][sel[3:0]] = d;
    if (code == CODE_XFER || code == CODE_EXT)
      r2 = r1;
  endfunction

  // external transfer pin, held a few cycles so the sync sees it
  task automatic ext_pulse();
    ext_xfer <= 1'b1;
    repeat (4) @(posedge clock);
    ext_xfer <= 1'b0;
  endtask

  // program count, start, answer the order request
  task automatic start_run(input logic [15:0] n, input logic [7:0] ob);
    apb(1'b1, REG_COUNT, {16'h0000, n});
    instr(I_START, dev_sw);
    `CHK(rd[RES_SIO_DONE], 1'b1)
    do @(posedge clock); while (order_req !== 1'b1);
    order_valid <= 1'b1;
    order_byte  <= ob;
    @(posedge clock);
    order_valid <= 1'b0;
  endtask

  // hand over one record, check bus and convert count; ext_ok fires the external transfer
  task automatic serve_rec(input logic [1:0] code, input logic [7:0] sel, input logic [15:0] d,
                           input logic ext_ok);
    logic [7:0] b [4];
    int         c0;
    b = '{{code, 6'($random(seed))}, sel, d[15:8], d[7:0]};
    do @(posedge clock); while (data_req !== 1'b1);
    for (int i = 0; i < 4; i++) begin
      data_valid <= 1'b1;
      data_byte  <= b[i];
      @(posedge clock);
    end
    data_valid <= 1'b0;
    model_rec(ext_ok ? code : CODE_LOAD, sel, d);
    c0 = n_conv;
    do @(posedge clock); while (bus_if.strobe !== 1'b1);
    `CHK(bus_if.sel, sel)
    `CHK(bus_if.data, d)
    do @(posedge clock); while (bus_if.strobe !== 1'b0);
    repeat (5) @(posedge clock);
    `CHK(n_conv, c0 + ((code == CODE_XFER) ? 1 : 0))
    if (code == CODE_EXT && ext_ok) begin
      ext_pulse();
      repeat (8) @(posedge clock);
      `CHK(n_conv, c0 + 1)
    end
  endtask

  initial begin
    logic [1:0]  code;
    logic [7:0]  sel;
    logic [15:0] d;
    clock = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, order_valid, data_valid, chan_halt, ext_xfer, cnv_q} = '0;
    {paddr, order_byte, data_byte, pwdata} = '0;
    fcu = 1'b1;
    seed = 32'h517f_7273;
    dev_sw = 8'($random(seed));
    r1 = '{default: '{default: 16'h0000}};
    r2 = r1;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    // unmapped place, zero count, foreign address, frequency unit status
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK(rerr, 1'b1)
    apb(1'b1, REG_COUNT, 32'h0000_0000);
    instr(I_START, dev_sw);
    `CHK(rd[RES_SIO_DONE], 1'b0)
    instr(I_TEST, dev_sw ^ 8'h01);
    `CHK(rd, 32'h0000_0000)
    instr(I_TDV, dev_sw);
    `CHK(rd[RES_FCU], 1'b1)
    // a nonzero count makes a start acceptable while idle
    apb(1'b1, REG_COUNT, 32'h0000_0008);
    instr(I_TEST, dev_sw);
    `CHK(rd[RES_SIO_OK:RES_ADDR_OK], 5'h11)
    // list of eight records, every control code first, then random ones
    start_run(16'h0008, ORDER_WRITE);
    instr(I_TEST, dev_sw);
    `CHK(rd[RES_BUSY], 1'b1)
    for (int i = 0; i < 8; i++) begin
      code = (i < 4) ? codes[i] : codes[$unsigned($random(seed)) % 4];
      sel = {nibs[$unsigned($random(seed)) % 3], 4'($random(seed))};
      d = 16'($random(seed));
      serve_rec(code, sel, d, 1'b1);
    end
    repeat (300) @(posedge clock);
    `CHK(n_chend, 1)
    `CHK(n_unus, 0)
    for (int k = 0; k < 16; k++) begin
      `CHK(ao0[k], r2[0][k])
    end
    for (int k = 0; k < 5; k++) begin
      `CHK(ao1[k], r2[1][k])
    end
    instr(I_ACK, dev_sw);
    `CHK(rd[RES_CAUSE+:2], CAUSE_CHEND)
    // channel halt while waiting for the external transfer
    start_run(16'h0002, ORDER_WRITE);
    serve_rec(CODE_EXT, 8'h03, 16'h8001, 1'b0);
    chan_halt <= 1'b1;
    repeat (3) @(posedge clock);
    chan_halt <= 1'b0;
    repeat (10) @(posedge clock);
    `CHK(n_unus, 1)
    `CHK(ao0[3], r2[0][3])
    instr(I_TEST, dev_sw);
    `CHK(rd[RES_UNUSUAL], 1'b1)
    `CHK(rd[RES_BUSY], 1'b0)
    // order byte other than write
    start_run(16'h0001, 8'h02);
    repeat (10) @(posedge clock);
    `CHK(n_unus, 2)
    // stray external edge while waiting for the order
    apb(1'b1, REG_COUNT, 32'h0000_0001);
    instr(I_START, dev_sw);
    do @(posedge clock); while (order_req !== 1'b1);
    ext_pulse();
    repeat (10) @(posedge clock);
    `CHK(n_unus, 3)
    `CHK(order_req, 1'b0)
    instr(I_TDV, dev_sw);
    `CHK(rd[RES_RATE_ERR], 1'b1)
    stop_test();
  end
endmodule
